// file: inc/pmc_pkg.sv
// Purpose: Constants and carrier types for the PHY miscellaneous config bank
// Assumes: AXI4-Lite slave, 32-bit data, register byte address = 4 x index
// Notes:   Register indices are kept as printed; byte address is derived
// How it works
// - In 10/100 MII mode the prefill depth counts bytes when the unit bit is one, nibbles when zero.
// - Byte units on the nibble MII bus double the internal prefill, so transmit latency grows.
// - The FIFO unit bit leaves reset at one, so byte prefill is the default.
// - A 16-bit counter counts each wake sequence that fails to finish in time.
// - Reading the wake fault counter returns the count and then clears it.
// - With retrain on, a bad receiver status at gigabit retrains, keeps link up and stalls data.
// - With retrain off, a bad receiver status at gigabit drops the link.
// - A gigabit retrain never makes the latched link status latch low.
// - The retrain enable is one read/write bit that resets to zero.
// - The reduced-voltage bit selects the low-swing 10 Mbps variant and resets to one.
// - Test waveform codes 1..4 pick 10 MHz or 5 MHz on dimension 0 or 1.
// - Code 000, the reset value, disables the test waveform; software avoids codes 101..111.
package pmc_pkg;
  localparam logic [15:0] PMC_IDX_FIFO_UNIT  = 16'h9602;
  localparam logic [15:0] PMC_IDX_WAKE_FAULT = 16'hA000;
  localparam logic [15:0] PMC_IDX_RETRAIN    = 16'hA001;
  localparam logic [15:0] PMC_IDX_TEN_E      = 16'hB403;
  localparam logic [15:0] PMC_IDX_TEN_TEST   = 16'hB412;
  localparam int          PMC_ADDR_W         = 18;
  localparam logic [0:0]  PMC_FIFO_UNIT_RST  = 1'h1;
  localparam logic [0:0]  PMC_RETRAIN_RST    = 1'h0;
  localparam logic [0:0]  PMC_TEN_E_RST      = 1'h1;
  localparam logic [2:0]  PMC_TEST_RST       = 3'h0;
  localparam logic [15:0] PMC_CNT_RST        = 16'h0000;
  localparam logic [15:0] PMC_CNT_MAX        = 16'hFFFF;
  localparam logic [1:0]  PMC_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  PMC_RESP_SLVERR    = 2'h2;
  localparam logic [6:0]  PMC_PREFILL_NIB    = 7'h08;
  // Test waveform selections
  typedef enum logic [2:0] {
    PMC_TW_OFF    = 3'b000,
    PMC_TW_10M_D0 = 3'b001,
    PMC_TW_10M_D1 = 3'b010,
    PMC_TW_5M_D0  = 3'b011,
    PMC_TW_5M_D1  = 3'b100
  } pmc_tw_t;
  // Waveform drive toward the analog front end
  typedef struct packed {
    logic enable;
    logic dim1;
    logic fast_10m;
  } pmc_wave_t;
  // Link status outputs toward the MAC side
  typedef struct packed {
    logic link_up;
    logic latched_link_status;
    logic data_stall;
    logic retraining;
  } pmc_link_t;
endpackage

// file: core/pmc_misc_regs.sv
// Purpose: PHY miscellaneous configuration and status registers on AXI4-Lite
// Assumes: Single clock, PHY events synchronous to i_sys_clk
// Notes:   One write and one read answered at a time; unmapped reads give SLVERR
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module pmc_misc_regs
  import pmc_pkg::*;
(
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  input  wire logic [31:0]        i_awaddr,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  output logic [1:0]              o_bresp,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  input  wire logic [31:0]        i_araddr,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp,
  output logic                    o_rvalid,
  input  wire logic               i_rready,
  input  wire logic               i_wake_fault,
  input  wire logic               i_gig_mode,
  input  wire logic               i_mii_mode,
  input  wire logic               i_link_ok,
  input  wire logic               i_rx_status_ok,
  input  wire logic               i_latch_clear,
  output logic [6:0]              o_prefill_nibbles,
  output logic                    o_ten_low_voltage,
  output pmc_pkg::pmc_wave_t      o_wave,
  output pmc_pkg::pmc_link_t      o_link
);
  import pmc_pkg::*;

  // Byte address to register index; low two bits ignored
  function automatic logic [15:0] pmc_index(input logic [31:0] addr);
    pmc_index = addr[PMC_ADDR_W-1:2];
  endfunction

  function automatic logic pmc_mapped(input logic [15:0] idx);
    pmc_mapped = (idx == PMC_IDX_FIFO_UNIT) || (idx == PMC_IDX_WAKE_FAULT) ||
                 (idx == PMC_IDX_RETRAIN) || (idx == PMC_IDX_TEN_E) ||
                 (idx == PMC_IDX_TEN_TEST);
  endfunction

  logic        fifo_unit_select_reg;
  logic        gigabit_retrain_enable_reg;
  logic        ten_e_enable_reg;
  logic [2:0]  ten_meg_test_waveform_select_reg;
  logic [15:0] wake_fault_count_reg;
  logic [15:0] wake_fault_count_next;
  logic        aw_held_reg;
  logic [15:0] aw_idx_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        retraining_reg;
  logic        link_up_reg;
  logic        latched_reg;

  // Write channel capture: address and data taken in either order
  wire aw_take  = i_awvalid && o_awready;
  wire w_take   = i_wvalid && o_wready;
  wire wr_fire  = aw_held_reg && w_held_reg && !o_bvalid;
  wire wr_lane0 = w_strb_reg[0];
  wire wr_lane1 = w_strb_reg[1];
  wire wr_fifo  = wr_fire && (aw_idx_reg == PMC_IDX_FIFO_UNIT) && wr_lane0;
  wire wr_rtrn  = wr_fire && (aw_idx_reg == PMC_IDX_RETRAIN) && wr_lane0;
  wire wr_tene  = wr_fire && (aw_idx_reg == PMC_IDX_TEN_E) && wr_lane0;
  wire wr_test  = wr_fire && (aw_idx_reg == PMC_IDX_TEN_TEST) && wr_lane0;
  wire wr_ok    = pmc_mapped(aw_idx_reg);
  wire wr_unused_lane = wr_lane1;

  // Read decode; counter clears only when its value is actually returned
  wire        ar_take  = i_arvalid && o_arready;
  wire [15:0] ar_idx   = pmc_index(i_araddr);
  wire        rd_wake  = ar_take && (ar_idx == PMC_IDX_WAKE_FAULT);
  wire [15:0] rd_value =
    (ar_idx == PMC_IDX_FIFO_UNIT)  ? {15'h0000, fifo_unit_select_reg} :
    (ar_idx == PMC_IDX_WAKE_FAULT) ? wake_fault_count_reg :
    (ar_idx == PMC_IDX_RETRAIN)    ? {15'h0000, gigabit_retrain_enable_reg} :
    (ar_idx == PMC_IDX_TEN_E)      ? {15'h0000, ten_e_enable_reg} :
    (ar_idx == PMC_IDX_TEN_TEST)   ? {13'h0000, ten_meg_test_waveform_select_reg} :
                                     16'h0000;

  // Read-clear vs new fault: a fault in the read cycle leaves a count of one
  always_comb begin
    wake_fault_count_next = wake_fault_count_reg;
    if (rd_wake) begin
      wake_fault_count_next = i_wake_fault ? 16'h0001 : PMC_CNT_RST;
    end else if (i_wake_fault && wake_fault_count_reg != PMC_CNT_MAX) begin
      wake_fault_count_next = wake_fault_count_reg + 16'h0001;
    end
  end

  // Bus handshake state
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= 16'h0000;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      o_awready   <= 1'b0;
      o_wready    <= 1'b0;
      o_bvalid    <= 1'b0;
      o_bresp     <= PMC_RESP_OKAY;
    end else begin
      o_awready <= !aw_held_reg && !aw_take && !o_bvalid;
      o_wready  <= !w_held_reg && !w_take && !o_bvalid;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= pmc_index(i_awaddr);
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        o_bvalid    <= 1'b1;
        o_bresp     <= wr_ok ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, data registered
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= PMC_RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !ar_take;
      if (ar_take) begin
        o_rvalid <= 1'b1;
        o_rdata  <= {16'h0000, rd_value};
        o_rresp  <= pmc_mapped(ar_idx) ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Control registers; only the low field bits are stored
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fifo_unit_select_reg             <= PMC_FIFO_UNIT_RST;
      gigabit_retrain_enable_reg       <= PMC_RETRAIN_RST;
      ten_e_enable_reg                 <= PMC_TEN_E_RST;
      ten_meg_test_waveform_select_reg <= PMC_TEST_RST;
      wake_fault_count_reg             <= PMC_CNT_RST;
    end else begin
      if (wr_fifo) fifo_unit_select_reg <= w_data_reg[0];
      if (wr_rtrn) gigabit_retrain_enable_reg <= w_data_reg[0];
      if (wr_tene) ten_e_enable_reg <= w_data_reg[0];
      if (wr_test) ten_meg_test_waveform_select_reg <= w_data_reg[2:0];
      wake_fault_count_reg <= wake_fault_count_next;
    end
  end

  // Gigabit receiver loss: retrain or drop depending on enable
  wire rx_bad      = i_gig_mode && !i_rx_status_ok && link_up_reg;
  wire do_retrain  = rx_bad && gigabit_retrain_enable_reg;
  wire do_drop     = rx_bad && !gigabit_retrain_enable_reg;
  // Hold the link down for as long as the receiver stays bad, not one cycle
  wire drop_hold   = i_gig_mode && !i_rx_status_ok && !gigabit_retrain_enable_reg;
  wire link_next   = (do_drop || drop_hold) ? 1'b0 : i_link_ok;

  // Latch stays high through retrain; only a real drop pulls it low
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      retraining_reg <= 1'b0;
      link_up_reg    <= 1'b0;
      latched_reg    <= 1'b0;
    end else begin
      retraining_reg <= do_retrain || (retraining_reg && !i_rx_status_ok && i_gig_mode);
      link_up_reg    <= link_next || (retraining_reg && i_link_ok);
      if (!link_next) latched_reg <= 1'b0;
      else if (i_latch_clear) latched_reg <= 1'b1;
    end
  end

  // Decode of the test waveform code; reserved codes treated as off
  pmc_tw_t tw_sel;
  assign tw_sel = pmc_tw_t'(ten_meg_test_waveform_select_reg);
  pmc_wave_t wave_next;
  always_comb begin
    wave_next = '0;
    case (tw_sel)
      PMC_TW_10M_D0: wave_next = '{enable: 1'b1, dim1: 1'b0, fast_10m: 1'b1};
      PMC_TW_10M_D1: wave_next = '{enable: 1'b1, dim1: 1'b1, fast_10m: 1'b1};
      PMC_TW_5M_D0:  wave_next = '{enable: 1'b1, dim1: 1'b0, fast_10m: 1'b0};
      PMC_TW_5M_D1:  wave_next = '{enable: 1'b1, dim1: 1'b1, fast_10m: 1'b0};
      PMC_TW_OFF:    wave_next = '0;
      default:       wave_next = '0;
    endcase
  end

  // Prefill size: byte units double the nibble count on the MII bus
  wire [6:0] prefill_next = (i_mii_mode && fifo_unit_select_reg) ?
                            {PMC_PREFILL_NIB[5:0], 1'b0} : PMC_PREFILL_NIB;

  // Registered side outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prefill_nibbles <= 7'h00;
      o_ten_low_voltage <= 1'b0;
      o_wave            <= '0;
      o_link            <= '0;
    end else begin
      o_prefill_nibbles <= prefill_next;
      o_ten_low_voltage <= ten_e_enable_reg;
      o_wave            <= wave_next;
      o_link            <= '{link_up: link_up_reg, latched_link_status: latched_reg,
                             data_stall: retraining_reg || wr_unused_lane && 1'b0,
                             retraining: retraining_reg};
    end
  end
endmodule // pmc_misc_regs

// file: tb/pmc_misc_regs_props.sv
// Purpose: Port relations of the misc config bank
// Assumes: One clock, async active-low reset
// Notes:   Sees the top ports only; bound below
`timescale 1ns/1ps
module pmc_misc_regs_chk
  import pmc_pkg::*;
(
  input logic               i_sys_clk,
  input logic               i_rst_n,
  input logic               i_arvalid,
  input logic               o_arready,
  input logic [31:0]        o_rdata,
  input logic [1:0]         o_rresp,
  input logic               o_rvalid,
  input logic               i_rready,
  input logic [1:0]         o_bresp,
  input logic               o_bvalid,
  input logic               i_bready,
  input logic               i_gig_mode,
  input logic               i_mii_mode,
  input logic               i_rx_status_ok,
  input logic [6:0]         o_prefill_nibbles,
  input pmc_pkg::pmc_link_t o_link
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Read answers arrive in the next cycle; read and write answers stand until taken
  property p_rd; i_arvalid && o_arready |=> o_rvalid; endproperty
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  property p_resv; o_rvalid && o_rresp == PMC_RESP_OKAY |-> o_rdata[31:16] == 16'h0;
  endproperty
  // Two cycles of settling: the prefill output is registered
  property p_pre; !i_mii_mode [*2] |-> o_prefill_nibbles == PMC_PREFILL_NIB; endproperty
  property p_rtr; o_link.retraining |-> o_link.link_up && o_link.data_stall; endproperty
  // Two registers stand between the receiver status and the link outputs
  property p_drop; i_gig_mode && !i_rx_status_ok |-> ##2 (!o_link.link_up || o_link.retraining);
  endproperty
  property p_lat; $fell(o_link.latched_link_status) |-> !o_link.link_up; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_resv: assert property (p_resv) else $error("upper bits not zero");
  a_pre: assert property (p_pre) else $error("prefill wrong");
  a_rtr: assert property (p_rtr) else $error("retrain lost link");
  a_drop: assert property (p_drop) else $error("link kept");
  a_lat: assert property (p_lat) else $error("latch fell while up");
  c_rtr: cover property (o_link.retraining);
  c_wr: cover property (o_bvalid && i_bready);
  c_err: cover property (o_rvalid && o_rresp == PMC_RESP_SLVERR);
endmodule // pmc_misc_regs_chk
bind pmc_misc_regs pmc_misc_regs_chk pmc_misc_regs_chk_i (.*);

// file: tb/pmc_phy_model.sv
// Purpose: Line side of the PHY seen by the config bank
// Assumes: Events synchronous to i_sys_clk
// Notes:   Driven through tasks by the bench
`timescale 1ns/1ps
module pmc_phy_model (
  input  logic i_sys_clk,
  output logic o_wake_fault = 1'h0,
  output logic o_gig_mode = 1'h0,
  output logic o_mii_mode = 1'h0,
  output logic o_link_ok = 1'h0,
  output logic o_rx_status_ok = 1'h0,
  output logic o_latch_clear = 1'h0
);
  // Gapped pulses so each counts as its own failed wake
  task automatic faults(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_wake_fault <= 1'h1;
      @(posedge i_sys_clk);
      o_wake_fault <= 1'h0;
    end
  endtask
  // State {gig, mii, link ok, rx ok}; clear is a one-cycle pulse
  task automatic line(input logic [3:0] v, input logic clr);
    @(posedge i_sys_clk);
    {o_gig_mode, o_mii_mode, o_link_ok, o_rx_status_ok} <= v;
    o_latch_clear <= clr;
    @(posedge i_sys_clk);
    o_latch_clear <= 1'h0;
  endtask
endmodule // pmc_phy_model

// file: tb/test_phy_misc_config_registers.sv
// Purpose: Self-checking bench for the misc config bank
// Assumes: 40 MHz clock, AXI4-Lite master tasks
// Notes:   Read answers checked by a queue monitor
`timescale 1ns/1ps
module test_phy_misc_config_registers;
  import pmc_pkg::*;
  logic i_sys_clk = 1'h0, i_rst_n = 1'h0;
  logic [31:0] i_awaddr = '0, i_wdata = '0, i_araddr = '0, o_rdata;
  logic [3:0] i_wstrb = '0;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic i_wake_fault, i_gig_mode, i_mii_mode, i_link_ok, i_rx_status_ok, i_latch_clear;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_ten_low_voltage;
  logic [1:0] o_bresp, o_rresp;
  logic [6:0] o_prefill_nibbles;
  pmc_wave_t o_wave;
  pmc_link_t o_link;
  logic [33:0] exq[$];
  int errors = 0, checks = 0;
  pmc_misc_regs pmc_misc_regs_i (.*);
  pmc_phy_model pmc_phy_model_i (.i_sys_clk(i_sys_clk), .o_wake_fault(i_wake_fault),
    .o_gig_mode(i_gig_mode), .o_mii_mode(i_mii_mode), .o_link_ok(i_link_ok),
    .o_rx_status_ok(i_rx_status_ok), .o_latch_clear(i_latch_clear));
  always #12.5 i_sys_clk = ~i_sys_clk;
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [33:0] s, input logic [33:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Each channel released at the edge that takes it; no fixed latency assumed
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge i_sys_clk);
    {i_awaddr, i_wdata, i_wstrb} <= {14'h0, idx, 2'h0, d, s};
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'h0;
      if (i_wvalid && o_wready) i_wvalid <= 1'h0;
      if (o_bvalid) break;
    end
    i_bready <= 1'h0;
    if (n == 50) begin errors++; report_and_stop; end
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] r = 2'h0);
    int n;
    exq.push_back({r, e});
    @(posedge i_sys_clk);
    i_araddr <= {14'h0, idx, 2'h0};
    {i_arvalid, i_rready} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'h0;
      if (o_rvalid) break;
    end
    i_rready <= 1'h0;
    if (n == 50) begin errors++; report_and_stop; end
  endtask
  // Oldest note against each accepted read answer
  always @(posedge i_sys_clk)
    if (o_rvalid && i_rready && exq.size() > 0)
      check({o_rresp, o_rdata}, exq.pop_front());
  initial begin
    int c;
    void'($urandom(32'h2245));
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'h1;
    @(posedge i_sys_clk);
    rd(PMC_IDX_FIFO_UNIT, 32'h1);
    rd(PMC_IDX_RETRAIN, 32'h0);
    rd(PMC_IDX_TEN_E, 32'h1);
    rd(PMC_IDX_TEN_TEST, {29'h0, PMC_TEST_RST});
    rd(16'h0001, 32'h0, PMC_RESP_SLVERR);
    check(o_ten_low_voltage, 1'h1);
    pmc_phy_model_i.faults(3);
    rd(PMC_IDX_WAKE_FAULT, 32'h3);
    rd(PMC_IDX_WAKE_FAULT, 32'h0);
    // Lane 0 strobe off: unit bit must hold at bytes
    pmc_phy_model_i.line(4'b0100, 1'h0);
    wr(PMC_IDX_FIFO_UNIT, 32'h0, 4'hE);
    check(o_prefill_nibbles, 7'h10);
    wr(PMC_IDX_FIFO_UNIT, $urandom() & 32'hFFFF_FFFE, 4'hF);
    repeat (2) @(posedge i_sys_clk);
    check(o_prefill_nibbles, PMC_PREFILL_NIB);
    rd(PMC_IDX_FIFO_UNIT, 32'h0);
    // Every defined code with random upper bits; reserved codes never written
    for (c = 0; c < 5; c++) begin
      wr(PMC_IDX_TEN_TEST, ($urandom() & 32'hFFFF_FFF8) | c, 4'hF);
      repeat (2) @(posedge i_sys_clk);
      check(o_wave, {c != 0, c == 2 || c == 4, c == 1 || c == 2});
      rd(PMC_IDX_TEN_TEST, c);
    end
    wr(PMC_IDX_TEN_E, 32'h0, 4'hF);
    repeat (2) @(posedge i_sys_clk);
    check(o_ten_low_voltage, 1'h0);
    // Gigabit link up then receiver fault, retrain off and then on
    for (c = 0; c < 2; c++) begin
      wr(PMC_IDX_RETRAIN, c, 4'hF);
      pmc_phy_model_i.line(4'b1011, 1'h0);
      pmc_phy_model_i.line(4'b1011, 1'h1);
      repeat (2) @(posedge i_sys_clk);
      check(o_link, 4'hC);
      pmc_phy_model_i.line(4'b1010, 1'h0);
      // Status is registered twice: look after the second edge, settled
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check(o_link, c ? 4'hF : 4'h0);
      // Leave gigabit mode so the next setting starts from a quiet line
      pmc_phy_model_i.line(4'b0000, 1'h0);
    end
    report_and_stop;
  end
endmodule // test_phy_misc_config_registers
